// >>> verilog/port_default_acl_action.sv
// Fallback classification action stage of the ingress pipeline
// Summary of operation
// [RULE1] On lookup miss with port fallback enabled, apply that port's entry.
// [RULE2] With port override set, apply the entry whether lookup hit or missed.
// [RULE3] Attach 16-bit CPU info; valid only when bit 0 is set.
// [RULE4] Mirror bit sends an unmodified copy to the 4-bit mirror port.
// [RULE5] Learning-suppress bit stops source address learning.
// [RULE6] Counter bit increments the match counter picked by 6-bit index.
// [RULE7] New TOS takes configured bits where mask is one, else packet bits.
// [RULE8] Ingress VID override replaces the ingress VID with 12-bit value.
// [RULE9] Outer DEI, PCP and VID each rewritten only by own enable.
// [RULE10] TPID select: 0 gives 8100, 1 gives 88a8, 2 user type.
// [RULE11] IPv4 source or destination address rewritten with 32-bit value.
// [RULE12] L4 source or destination port rewritten with 16-bit value.
// [RULE13] Drop bit discards packet and bumps the drop counter.
// [RULE14] CPU redirect; unmodified-copy bit sends original packet.
// [RULE15] Port redirect forwards to the 4-bit target port.
// [RULE16] Timestamp bit with CPU redirect bit sets CPU tag flag and carries packet timestamp.
// [RULE17] Encap uses 4-bit index; pick 0 unicast, 1 multicast table.
// [RULE18] Color override assigns the 2-bit color.
// [RULE19] Meter reference valid uses 5-bit index and 2-bit rank.
// [RULE20] Queue override assigns the 3-bit egress queue.
// [RULE21] Translation valid applies NAT operation at 11-bit index.
// [RULE22] Without fallback or override, result passes through unchanged.
`timescale 1ns/100ps
`include "port_default_acl_defines.svh"
module port_default_acl_action
    import port_default_acl_pkg::*;
#(
    parameter int NUM_PORTS = `PDA_NUM_PORTS
) (
    input wire logic sys_clk,
    input wire logic nrst,
    // Configuration port, word addressed
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [15:0] cfg_addr,
    input wire logic [`PDA_WORD_W-1:0] cfg_wdata,
    output logic [`PDA_WORD_W-1:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic [NUM_PORTS-1:0] port_fallback_on_miss,
    input wire logic [NUM_PORTS-1:0] port_action_override,
    // Lookup result in
    input wire logic in_valid,
    input wire port_default_acl_pkg::port_t in_src_port,
    input wire logic in_hit,
    input wire logic [7:0] in_tos,
    input wire logic [11:0] in_ingress_vid,
    input wire logic in_outer_dei,
    input wire logic [2:0] in_outer_prio,
    input wire logic [11:0] in_outer_vid,
    input wire logic [15:0] in_outer_tpid,
    input wire logic in_is_ipv4,
    input wire logic [31:0] in_ipv4_sa,
    input wire logic [31:0] in_ipv4_da,
    input wire logic [15:0] in_l4_sp,
    input wire logic [15:0] in_l4_dp,
    input wire logic [31:0] in_timestamp,
    input wire logic [15:0] user_vlan_type,
    input wire port_default_acl_pkg::entry_t in_result,
    // Result out
    output logic out_valid,
    output logic out_applied,
    output port_default_acl_pkg::entry_t out_result,
    output logic [7:0] out_tos,
    output logic [11:0] out_ingress_vid,
    output logic out_outer_dei,
    output logic [2:0] out_outer_prio,
    output logic [11:0] out_outer_vid,
    output logic [15:0] out_outer_tpid,
    output logic [31:0] out_ipv4_sa,
    output logic [31:0] out_ipv4_da,
    output logic [15:0] out_l4_sp,
    output logic [15:0] out_l4_dp,
    output logic out_ts_flag,
    output logic [31:0] out_timestamp,
    output logic cnt_match_inc,
    output logic [5:0] cnt_match_index,
    output logic cnt_drop_inc
);
    import port_default_acl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Entry storage and config decode
    typedef struct packed {
        logic valid;
        logic applied;
        entry_t res;
        logic [7:0] tos;
        logic [11:0] ivid;
        logic dei;
        logic [2:0] prio;
        logic [11:0] ovid;
        logic [15:0] tpid;
        logic [31:0] sa;
        logic [31:0] da;
        logic [15:0] sp;
        logic [15:0] dp;
        logic ts_flag;
        logic [31:0] ts;
        logic cnt_inc;
        logic [5:0] cnt_idx;
        logic drop_inc;
        logic [`PDA_WORD_W-1:0] rdata;
        logic rvalid;
    } stage_s;

    stage_s st;
    stage_s next_st;
    entry_t ent;
    logic [`PDA_WORD_W-1:0] cfg_word;
    logic [15:0] rel;
    logic in_range;

    function automatic logic tab_hit(input logic [15:0] a);
        tab_hit = a >= `PDA_TABLE_BASE &&
            a < `PDA_TABLE_BASE + 16'(NUM_PORTS * `PDA_WORDS_PER_ENTRY);
    endfunction : tab_hit

    assign rel = cfg_addr - `PDA_TABLE_BASE;
    assign in_range = tab_hit(cfg_addr);

    pda_entry_store #(
        .NUM_PORTS(NUM_PORTS)
    ) u_store (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .wr_en(cfg_wr && in_range),
        .wr_index(rel[6:0]),
        .wr_data(cfg_wdata),
        .rd_port(in_src_port),
        .rd_entry(ent),
        .cfg_index(rel[6:0]),
        .cfg_word(cfg_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Action application
    logic apply;
    logic sel_ok;

    assign sel_ok = in_src_port < 4'(NUM_PORTS);
    assign apply = in_valid && sel_ok &&
        ((port_fallback_on_miss[in_src_port] && !in_hit) ||  // [RULE1]
         port_action_override[in_src_port]);                // [RULE2]

    always_comb begin
        next_st = st;
        next_st.valid = in_valid;
        next_st.applied = apply;
        next_st.rvalid = cfg_rd;
        next_st.rdata = (cfg_rd && in_range) ? cfg_word : '0;
        // Pass-through by default
        next_st.res = in_result;                            // [RULE22]
        next_st.tos = in_tos;
        next_st.ivid = in_ingress_vid;
        next_st.dei = in_outer_dei;
        next_st.prio = in_outer_prio;
        next_st.ovid = in_outer_vid;
        next_st.tpid = in_outer_tpid;
        next_st.sa = in_ipv4_sa;
        next_st.da = in_ipv4_da;
        next_st.sp = in_l4_sp;
        next_st.dp = in_l4_dp;
        next_st.ts_flag = 1'b0;
        next_st.ts = '0;
        next_st.cnt_inc = 1'b0;
        next_st.cnt_idx = '0;
        next_st.drop_inc = 1'b0;
        if (apply) begin
            // Entry replaces the lookup result; carries CPU info, mirror,
            // learn, redirect, encap, color, meter, queue, NAT fields
            next_st.res = ent;                  // [RULE2] [RULE3] [RULE4]
            // [RULE5] [RULE14] [RULE15] [RULE17] [RULE18] [RULE19]
            // [RULE20] [RULE21] carried in the entry image above
            if (ent[`PDA_CNT_ON]) begin
                next_st.cnt_inc = 1'b1;                     // [RULE6]
                next_st.cnt_idx = ent[`PDA_CNT_LO +: 6];
            end
            if (ent[`PDA_TOS_ON]) begin
                next_st.tos = (ent[`PDA_TOS_VAL_LO +: 8] &
                    ent[`PDA_TOS_MASK_LO +: 8]) |
                    (in_tos & ~ent[`PDA_TOS_MASK_LO +: 8]); // [RULE7]
            end
            if (ent[`PDA_VIDO_ON]) begin
                next_st.ivid = ent[`PDA_VIDO_LO +: 12];     // [RULE8]
            end
            if (ent[`PDA_DEI_ON]) begin
                next_st.dei = ent[`PDA_DEI_VAL];            // [RULE9]
            end
            if (ent[`PDA_PRIO_ON]) begin
                next_st.prio = ent[`PDA_PRIO_LO +: 3];      // [RULE9]
            end
            if (ent[`PDA_OVID_ON]) begin
                next_st.ovid = ent[`PDA_OVID_LO +: 12];     // [RULE9]
            end
            if (ent[`PDA_TPID_ON]) begin
                case (tpid_sel_e'(ent[`PDA_TPID_SEL_LO +: 2]))  // [RULE10]
                    tpid_c: next_st.tpid = `PDA_TPID_C;
                    tpid_s: next_st.tpid = `PDA_TPID_S;
                    tpid_user: next_st.tpid = user_vlan_type;
                    default: next_st.tpid = in_outer_tpid;
                endcase
            end
            if (ent[`PDA_IP_ON] && in_is_ipv4) begin        // [RULE11]
                if (ent[`PDA_IP_PICK]) begin
                    next_st.da = ent[`PDA_IP_LO +: 32];
                end else begin
                    next_st.sa = ent[`PDA_IP_LO +: 32];
                end
            end
            if (ent[`PDA_L4_ON]) begin                      // [RULE12]
                if (ent[`PDA_L4_PICK]) begin
                    next_st.dp = ent[`PDA_L4_LO +: 16];
                end else begin
                    next_st.sp = ent[`PDA_L4_LO +: 16];
                end
            end
            next_st.drop_inc = ent[`PDA_DISCARD];           // [RULE13]
            if (ent[`PDA_TS_ON] && ent[`PDA_CPU_RED]) begin // [RULE16]
                next_st.ts_flag = 1'b1;
                next_st.ts = in_timestamp;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign out_valid = st.valid;
    assign out_applied = st.applied;
    assign out_result = st.res;
    assign out_tos = st.tos;
    assign out_ingress_vid = st.ivid;
    assign out_outer_dei = st.dei;
    assign out_outer_prio = st.prio;
    assign out_outer_vid = st.ovid;
    assign out_outer_tpid = st.tpid;
    assign out_ipv4_sa = st.sa;
    assign out_ipv4_da = st.da;
    assign out_l4_sp = st.sp;
    assign out_l4_dp = st.dp;
    assign out_ts_flag = st.ts_flag;
    assign out_timestamp = st.ts;
    assign cnt_match_inc = st.cnt_inc;
    assign cnt_match_index = st.cnt_idx;
    assign cnt_drop_inc = st.drop_inc;
    assign cfg_rdata = st.rdata;
    assign cfg_rvalid = st.rvalid;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_MISS_APPLY: assert property (@(posedge sys_clk) disable iff (!nrst)
        in_valid && sel_ok && !in_hit && port_fallback_on_miss[in_src_port]
        |=> out_applied && out_result == $past(ent)) // [RULE1]
        else $error("fallback entry not applied on miss");
    AST_FORCE_APPLY: assert property (@(posedge sys_clk) disable iff (!nrst)
        in_valid && sel_ok && port_action_override[in_src_port]
        |=> out_applied) // [RULE2]
        else $error("override entry not applied");
    AST_PASS: assert property (@(posedge sys_clk) disable iff (!nrst)
        !apply |=> !out_applied && out_result == $past(in_result)
        && out_tos == $past(in_tos)) // [RULE22]
        else $error("result changed without fallback");
    AST_CNT: assert property (@(posedge sys_clk) disable iff (!nrst)
        apply && ent[`PDA_CNT_ON] |=> cnt_match_inc
        && cnt_match_index == $past(ent[29:24])) // [RULE6]
        else $error("match counter not bumped");
    AST_TOS: assert property (@(posedge sys_clk) disable iff (!nrst)
        apply && ent[`PDA_TOS_ON] |=> out_tos == (($past(ent[38:31]) &
        $past(ent[46:39])) | ($past(in_tos) & ~$past(ent[46:39])))) // [RULE7]
        else $error("tos merge wrong");
    AST_VID: assert property (@(posedge sys_clk) disable iff (!nrst)
        apply && ent[`PDA_VIDO_ON] |=> out_ingress_vid == $past(ent[59:48]))
        // [RULE8]
        else $error("ingress vid not overridden");
    AST_TPID: assert property (@(posedge sys_clk) disable iff (!nrst)
        apply && ent[`PDA_TPID_ON] && ent[81:80] == 2'h1
        |=> out_outer_tpid == 16'h88a8) // [RULE10]
        else $error("tpid select wrong");
    AST_DROP: assert property (@(posedge sys_clk) disable iff (!nrst)
        cnt_drop_inc |-> $past(apply) && $past(ent[`PDA_DISCARD])) // [RULE13]
        else $error("drop counter bumped without cause");
    AST_L4: assert property (@(posedge sys_clk) disable iff (!nrst)
        apply && ent[`PDA_L4_ON] && ent[`PDA_L4_PICK]
        |=> out_l4_dp == $past(ent[133:118]) && out_l4_sp == $past(in_l4_sp))
        // [RULE12]
        else $error("l4 port rewrite wrong");
endmodule : port_default_acl_action

// >>> include/port_default_acl_defines.svh
// Offsets, field positions, reset values and sizes of the fallback action stage
`ifndef PORT_DEFAULT_ACL_DEFINES_SVH
`define PORT_DEFAULT_ACL_DEFINES_SVH

`define PDA_TABLE_BASE 16'had1e
`define PDA_NUM_PORTS 11
`define PDA_ENTRY_W 176
`define PDA_ENTRY_RESET 176'h0
`define PDA_WORDS_PER_ENTRY 8
`define PDA_WORD_W 22

`define PDA_CPU_VALID 0
`define PDA_CPU_VAL_LO 1
`define PDA_COPY_ON 17
`define PDA_COPY_PORT_LO 18
`define PDA_SKIP_LEARN 22
`define PDA_CNT_ON 23
`define PDA_CNT_LO 24
`define PDA_TOS_ON 30
`define PDA_TOS_VAL_LO 31
`define PDA_TOS_MASK_LO 39
`define PDA_VIDO_ON 47
`define PDA_VIDO_LO 48
`define PDA_DEI_ON 60
`define PDA_DEI_VAL 61
`define PDA_PRIO_ON 62
`define PDA_PRIO_LO 63
`define PDA_OVID_ON 66
`define PDA_OVID_LO 67
`define PDA_TPID_ON 79
`define PDA_TPID_SEL_LO 80
`define PDA_IP_ON 82
`define PDA_IP_PICK 83
`define PDA_IP_LO 84
`define PDA_L4_ON 116
`define PDA_L4_PICK 117
`define PDA_L4_LO 118
`define PDA_DISCARD 134
`define PDA_CPU_RED 135
`define PDA_CPU_ORIG 136
`define PDA_PORT_RED 137
`define PDA_PORT_TGT_LO 138
`define PDA_TS_ON 142
`define PDA_ENC_ON 143
`define PDA_ENC_PICK 144
`define PDA_ENC_LO 145
`define PDA_COLOR_ON 149
`define PDA_COLOR_LO 150
`define PDA_METER_ON 152
`define PDA_METER_LO 153
`define PDA_RANK_LO 158
`define PDA_QUEUE_ON 160
`define PDA_QUEUE_LO 161
`define PDA_XLATE_ON 164
`define PDA_XLATE_LO 165

`define PDA_TPID_C 16'h8100
`define PDA_TPID_S 16'h88a8

`endif

// >>> include/port_default_acl_pkg.sv
// Types shared by the fallback action stage
package port_default_acl_pkg;
    typedef logic [3:0] port_t;
    typedef logic [175:0] entry_t;
    typedef enum logic [1:0] {
        tpid_c,
        tpid_s,
        tpid_user,
        tpid_rsvd
    } tpid_sel_e;
endpackage : port_default_acl_pkg

// >>> verilog/pda_entry_store.sv
// Per-port action entry storage, written as 22-bit words by the config port
`timescale 1ns/100ps
`include "port_default_acl_defines.svh"
module pda_entry_store
    import port_default_acl_pkg::*;
#(
    parameter int NUM_PORTS = `PDA_NUM_PORTS
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [6:0] wr_index,
    input wire logic [`PDA_WORD_W-1:0] wr_data,
    input wire port_t rd_port,
    output port_default_acl_pkg::entry_t rd_entry,
    input wire logic [6:0] cfg_index,
    output logic [`PDA_WORD_W-1:0] cfg_word
);
    import port_default_acl_pkg::*;

    typedef struct packed {
        entry_t [NUM_PORTS-1:0] tab;
    } store_s;

    store_s st;
    store_s next_st;
    logic [3:0] wp;
    logic [2:0] ww;
    logic [3:0] rp;
    logic [2:0] rw;

    assign wp = wr_index[6:3];
    assign ww = wr_index[2:0];
    assign rp = cfg_index[6:3];
    assign rw = cfg_index[2:0];

    always_comb begin
        next_st = st;
        if (wr_en && wp < 4'(NUM_PORTS)) begin
            next_st.tab[wp][ww*`PDA_WORD_W +: `PDA_WORD_W] = wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_entry = (rd_port < 4'(NUM_PORTS)) ? st.tab[rd_port] : '0;
    assign cfg_word = (rp < 4'(NUM_PORTS)) ?
        st.tab[rp][rw*`PDA_WORD_W +: `PDA_WORD_W] : '0;
endmodule : pda_entry_store

// >>> tb/lookup_model.sv
// Lookup side model presenting one classification result per request
`timescale 1ns/100ps
module lookup_model
    import port_default_acl_pkg::*;
(
    input wire logic req,
    input wire port_t port,
    input wire logic hit,
    input wire logic ipv4,
    input wire logic [3:0] seed,
    output logic in_valid,
    output port_default_acl_pkg::port_t in_src_port,
    output logic in_hit,
    output logic in_is_ipv4,
    output logic [147:0] fields,
    output logic [31:0] in_timestamp,
    output port_default_acl_pkg::entry_t in_result
);
    logic [355:0] img;

    // Idle lines show the inverse so stale values cannot pass for a result
    assign img = {89{seed}};
    assign in_valid = req;
    assign in_src_port = req ? port : ~port;
    assign in_hit = req ? hit : ~hit;
    assign in_is_ipv4 = req ? ipv4 : ~ipv4;
    assign {fields, in_timestamp, in_result} = req ? img : ~img;
endmodule : lookup_model

// >>> tb/port_default_acl_action_tb.sv
// Self-checking bench for the fallback action stage
`timescale 1ns/100ps
`include "port_default_acl_defines.svh"
module port_default_acl_action_tb;
    import port_default_acl_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [15:0] cfg_addr = 16'h0;
    logic [21:0] cfg_wdata = 22'h0;
    logic [10:0] port_fallback_on_miss = 11'h0;
    logic [10:0] port_action_override = 11'h0;
    logic req = 1'b0;
    port_t port = 4'h0;
    logic hit = 1'b0;
    logic ipv4 = 1'b0;
    logic [3:0] seed = 4'h0;
    logic [15:0] user_vlan_type = 16'h9100;
    logic [21:0] cfg_rdata;
    logic cfg_rvalid, in_valid, in_hit, in_is_ipv4, out_valid, out_applied;
    logic out_ts_flag, cnt_match_inc, cnt_drop_inc;
    logic [5:0] cnt_match_index;
    logic [31:0] in_timestamp, out_timestamp;
    port_t in_src_port;
    entry_t in_result, out_result;
    wire [147:0] fields, outs;
    int fails = 0;
    int total_checks = 0;

    always #25 sys_clk = ~sys_clk;

    lookup_model lookup_model_inst (
        .req(req), .port(port), .hit(hit), .ipv4(ipv4), .seed(seed),
        .in_valid(in_valid), .in_src_port(in_src_port), .in_hit(in_hit),
        .in_is_ipv4(in_is_ipv4), .fields(fields),
        .in_timestamp(in_timestamp), .in_result(in_result)
    );

    port_default_acl_action #(.NUM_PORTS(11)) port_default_acl_action_inst (
        .sys_clk(sys_clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid),
        .port_fallback_on_miss(port_fallback_on_miss),
        .port_action_override(port_action_override), .in_valid(in_valid),
        .in_src_port(in_src_port), .in_hit(in_hit), .in_tos(fields[147:140]),
        .in_ingress_vid(fields[139:128]), .in_outer_dei(fields[127]),
        .in_outer_prio(fields[126:124]), .in_outer_vid(fields[123:112]),
        .in_outer_tpid(fields[111:96]), .in_is_ipv4(in_is_ipv4),
        .in_ipv4_sa(fields[95:64]), .in_ipv4_da(fields[63:32]),
        .in_l4_sp(fields[31:16]), .in_l4_dp(fields[15:0]),
        .in_timestamp(in_timestamp), .user_vlan_type(user_vlan_type),
        .in_result(in_result), .out_valid(out_valid),
        .out_applied(out_applied), .out_result(out_result),
        .out_tos(outs[147:140]), .out_ingress_vid(outs[139:128]),
        .out_outer_dei(outs[127]), .out_outer_prio(outs[126:124]),
        .out_outer_vid(outs[123:112]), .out_outer_tpid(outs[111:96]),
        .out_ipv4_sa(outs[95:64]), .out_ipv4_da(outs[63:32]),
        .out_l4_sp(outs[31:16]), .out_l4_dp(outs[15:0]),
        .out_ts_flag(out_ts_flag), .out_timestamp(out_timestamp),
        .cnt_match_inc(cnt_match_inc), .cnt_match_index(cnt_match_index),
        .cnt_drop_inc(cnt_drop_inc)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input entry_t e, input entry_t g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic final_report();
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic cfg_write(input logic [15:0] a, input logic [21:0] d);
        @(negedge sys_clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge sys_clk);
        cfg_wr = 1'b0;
    endtask : cfg_write

    // Read answer stands one cycle after the request edge
    task automatic cfg_read(input logic [15:0] a, input logic [21:0] d);
        @(negedge sys_clk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge sys_clk);
        cfg_rd = 1'b0;
        chk("rvalid", 176'(1'b1), 176'(cfg_rvalid));
        chk("rdata", 176'(d), 176'(cfg_rdata));
    endtask : cfg_read

    task automatic wr_entry(input port_t p, input entry_t e);
        for (int w = 0; w < 8; w++) begin
            cfg_write(16'(`PDA_TABLE_BASE + p * 8 + w), e[22 * w +: 22]);
        end
    endtask : wr_entry

    task automatic rd_entry(input port_t p, input entry_t e);
        for (int w = 0; w < 8; w++) begin
            cfg_read(16'(`PDA_TABLE_BASE + p * 8 + w), e[22 * w +: 22]);
        end
    endtask : rd_entry

    function automatic entry_t mk(input logic [1:0] s, input logic pk,
                                  input logic on);
        entry_t e;
        int onb[12] = '{23, 30, 47, 60, 62, 66, 79, 82, 116, 134, 135, 142};
        e = {8{22'h2d4b69}};
        foreach (onb[i]) e[onb[i]] = on;
        e[81:80] = s;
        e[83] = pk;
        e[117] = ~pk;
        return e;
    endfunction : mk

    // One packet; e is the entry held for port p
    task automatic pkt(input port_t p, input logic h, input logic v4,
                       input entry_t e);
        logic ap;
        logic [147:0] x;
        logic [31:0] ts;
        entry_t r;
        ap = p < 4'hb && (port_action_override[p] ||
             port_fallback_on_miss[p] && !h);
        @(negedge sys_clk);
        req = 1'b1;
        port = p;
        hit = h;
        ipv4 = v4;
        seed = seed + 4'h3;
        @(negedge sys_clk);
        x = fields;
        ts = in_timestamp;
        r = in_result;
        req = 1'b0;
        if (ap) begin
            if (e[30]) x[147:140] = e[38:31] & e[46:39] | x[147:140] & ~e[46:39];
            if (e[47]) x[139:128] = e[59:48];
            if (e[60]) x[127] = e[61];
            if (e[62]) x[126:124] = e[65:63];
            if (e[66]) x[123:112] = e[78:67];
            if (e[79] && e[81:80] != 2'h3) begin
                x[111:96] = e[81] ? user_vlan_type : e[80] ? 16'h88a8 : 16'h8100;
            end
            if (e[82] && v4) x[(e[83] ? 63 : 95) -: 32] = e[115:84];
            if (e[116]) x[(e[117] ? 15 : 31) -: 16] = e[133:118];
        end
        chk("valid", 176'(1'b1), 176'(out_valid));
        chk("applied", 176'(ap), 176'(out_applied));
        chk("result", ap ? e : r, out_result);
        chk("fields", 176'(x), 176'(outs));
        chk("match", 176'(ap && e[23] ? {e[29:24], 1'b1} : 7'h0),
            176'({cnt_match_inc ? cnt_match_index : 6'h0, cnt_match_inc}));
        chk("drop", 176'(ap && e[134]), 176'(cnt_drop_inc));
        chk("tstamp", 176'(ap && e[142] && e[135] ? {ts, 1'b1} : 33'h0),
            176'({out_ts_flag ? out_timestamp : 32'h0, out_ts_flag}));
    endtask : pkt

    ////////////////////////////////////////////////////////////////////////
    task automatic s_reset();
        cfg_write(16'had1d, 22'h3fffff);
        cfg_read(16'had1e, 22'h0);
        cfg_read(16'had75, 22'h0);
        cfg_read(16'had76, 22'h0);
        cfg_read(16'had1d, 22'h0);
        pkt(4'h0, 1'b0, 1'b1, '0);
    endtask : s_reset

    task automatic s_fallback();
        entry_t e;
        e = mk(2'h1, 1'b0, 1'b1);
        wr_entry(4'h3, e);
        rd_entry(4'h3, e);
        port_fallback_on_miss[3] = 1'b1;
        pkt(4'h3, 1'b0, 1'b1, e);
        pkt(4'h3, 1'b1, 1'b1, e);
        pkt(4'h4, 1'b0, 1'b1, '0);
        port_action_override[3] = 1'b1;
        pkt(4'h3, 1'b1, 1'b1, e);
        pkt(4'h3, 1'b0, 1'b0, e);
        port_action_override[3] = 1'b0;
    endtask : s_fallback

    task automatic s_codes();
        entry_t e;
        port_fallback_on_miss[5] = 1'b1;
        for (int s = 0; s < 4; s++) begin
            e = mk(2'(s), s[0], 1'b1);
            wr_entry(4'h5, e);
            pkt(4'h5, 1'b0, 1'b1, e);
        end
        e = mk(2'h2, 1'b1, 1'b0);
        wr_entry(4'h5, e);
        pkt(4'h5, 1'b0, 1'b1, e);
    endtask : s_codes

    task automatic s_bad_port();
        entry_t e;
        port_fallback_on_miss = 11'h7ff;
        port_action_override = 11'h7ff;
        e = mk(2'h0, 1'b1, 1'b1);
        wr_entry(4'ha, e);
        pkt(4'ha, 1'b1, 1'b1, e);
        pkt(4'hb, 1'b0, 1'b1, e);
        pkt(4'hf, 1'b1, 1'b1, e);
    endtask : s_bad_port

    initial begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        nrst = 1'b1;
        s_reset();
        s_fallback();
        s_codes();
        s_bad_port();
        final_report();
    end
endmodule : port_default_acl_action_tb
